// [hdl/rate_cfg_regs.vh]
// register map, field layout and timing constants of the rate config block
`ifndef RATE_CFG_REGS_VH
`define RATE_CFG_REGS_VH

// register indices; byte address is four times the index
`define PRI_CFG_IDX        8'h32
`define SEC_CFG_IDX        8'h33
`define STATUS_IDX         8'h38
`define PRI_CFG_ADDR       10'h0c8
`define SEC_CFG_ADDR       10'h0cc
`define STATUS_ADDR        10'h0e0
`define ADDR_W             10

`define CFG_RESET          8'h00
`define CODE_MSB           7
`define CODE_LSB           2
`define TOL_BIT            1
`define MODE_BIT           0
`define CODE_W             6

// status layout
`define ST_PRI_CODE_LSB    0
`define ST_PRI_VALID_BIT   6
`define ST_SEC_CODE_LSB    8
`define ST_SEC_VALID_BIT   14
`define ST_MANUAL_BIT      16

// htrans values, hsize word
`define HTRANS_NONSEQ      2'h2
`define HSIZE_WORD         3'h2

// rate codes
`define CODE_AUTO          6'h00
`define CODE_FIRST         6'h01
`define CODE_LAST          6'h28

// timing: clock rate in Hz, every standard rate is BASE/divisor
`define MCLK_HZ            56'h00000001312d00
`define RATE_BASE_HZ       56'h000000002ee000
`define PCT_SCALE          56'h00000000000064
`define TOL_NARROW_PCT_LO  56'h00000000000063
`define TOL_NARROW_PCT_HI  56'h00000000000065
`define TOL_WIDE_PCT_LO    56'h0000000000005f
`define TOL_WIDE_PCT_HI    56'h00000000000069
// accepted band of an explicit code: 0.8728 .. 1.03 of typical
`define BAND_LO_NUM        56'h00000000002218
`define BAND_LO_DEN        56'h00000000002710
`define BAND_HI_NUM        56'h00000000000067
`define BAND_HI_DEN        56'h00000000000064

`endif

// [hdl/rate_classifier.v]
// one port's frame-rate measurement and standard rate classification
`timescale 1ns/1ns
`include "rate_cfg_regs.vh"
module rate_classifier #(
  parameter CNT_W = 16
) (
  input  wire                mclk,      // device clock
  input  wire                rst_n,     // synchronised reset
  input  wire                ce,        // clock enable
  input  wire                fs_rise,   // frame start pulse
  input  wire [`CODE_W-1:0]  code,      // programmed rate code
  input  wire                tol_wide,  // 5% when set, else 1%
  output reg  [`CODE_W-1:0]  rate_q,    // resolved rate code
  output reg                 valid_q    // rate accepted
);
  localparam [1:0] S_IDLE = 2'b01;
  localparam [1:0] S_SCAN = 2'b10;
  localparam [CNT_W-1:0] CNT_MAX = {CNT_W{1'b1}};

  reg [1:0]         state_q;
  reg [CNT_W-1:0]   cnt_q;
  reg [CNT_W-1:0]   period_q;
  reg [`CODE_W-1:0] idx_q;
  reg [10:0]        div;

  // standard rates are 3.072 MHz divided by this
  always @* begin
    case (idx_q)
      6'h01: div = 11'h004; 6'h02: div = 11'h005; 6'h03: div = 11'h006;
      6'h04: div = 11'h007; 6'h05: div = 11'h008; 6'h06: div = 11'h009;
      6'h07: div = 11'h00a; 6'h08: div = 11'h00c; 6'h09: div = 11'h00e;
      6'h0a: div = 11'h010; 6'h0b: div = 11'h012; 6'h0c: div = 11'h014;
      6'h0d: div = 11'h018; 6'h0e: div = 11'h01c; 6'h0f: div = 11'h020;
      6'h10: div = 11'h024; 6'h11: div = 11'h028; 6'h12: div = 11'h030;
      6'h13: div = 11'h038; 6'h14: div = 11'h040; 6'h15: div = 11'h048;
      6'h16: div = 11'h050; 6'h17: div = 11'h060; 6'h18: div = 11'h070;
      6'h19: div = 11'h080; 6'h1a: div = 11'h090; 6'h1b: div = 11'h0a0;
      6'h1c: div = 11'h0c0; 6'h1d: div = 11'h0e0; 6'h1e: div = 11'h100;
      6'h1f: div = 11'h120; 6'h20: div = 11'h140; 6'h21: div = 11'h180;
      6'h22: div = 11'h1c0; 6'h23: div = 11'h200; 6'h24: div = 11'h240;
      6'h25: div = 11'h280; 6'h26: div = 11'h300; 6'h27: div = 11'h380;
      6'h28: div = 11'h400;
      default: div = 11'h000;
    endcase
  end

  // measured rate vs typical: compare period*base against clock*divisor
  wire [55:0] pb  = {{(56-CNT_W){1'b0}}, period_q} * `RATE_BASE_HZ;
  wire [55:0] fd  = `MCLK_HZ * {45'h0, div};
  wire [55:0] plo = tol_wide ? `TOL_WIDE_PCT_LO : `TOL_NARROW_PCT_LO;
  wire [55:0] phi = tol_wide ? `TOL_WIDE_PCT_HI : `TOL_NARROW_PCT_HI;
  wire in_tol  = (pb * `PCT_SCALE >= fd * plo) &&
                 (pb * `PCT_SCALE <= fd * phi);
  wire in_band = (fd * `BAND_LO_DEN >= pb * `BAND_LO_NUM) &&
                 (fd * `BAND_HI_DEN <= pb * `BAND_HI_NUM);
  wire is_auto  = (code == `CODE_AUTO);
  wire reserved = (code > `CODE_LAST);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q  <= S_IDLE;
      cnt_q    <= {CNT_W{1'b0}};
      period_q <= {CNT_W{1'b0}};
      idx_q    <= `CODE_AUTO;
      rate_q   <= `CODE_AUTO;
      valid_q  <= 1'b0;
    end else if (ce) begin
      if (fs_rise)
        cnt_q <= {CNT_W{1'b0}};
      else if (cnt_q != CNT_MAX)
        cnt_q <= cnt_q + 1'b1;
      // a stalled frame clock drops the lock
      if (cnt_q == CNT_MAX)
        valid_q <= 1'b0;
      case (state_q)
        S_IDLE: begin
          if (fs_rise) begin
            period_q <= cnt_q + 1'b1;
            idx_q    <= is_auto ? `CODE_FIRST : code;
            if (reserved) begin
              rate_q  <= `CODE_AUTO;
              valid_q <= 1'b0;
            end else
              state_q <= S_SCAN;
          end
        end
        S_SCAN: begin
          if (!is_auto) begin
            rate_q  <= idx_q;
            valid_q <= in_band;
            state_q <= S_IDLE;
          end else if (in_tol) begin
            // rates lie over 10% apart, so the first hit is the nearest
            rate_q  <= idx_q;
            valid_q <= 1'b1;
            state_q <= S_IDLE;
          end else if (idx_q == `CODE_LAST) begin
            rate_q  <= `CODE_AUTO;
            valid_q <= 1'b0;
            state_q <= S_IDLE;
          end else
            idx_q <= idx_q + 1'b1;
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule // rate_classifier

// [hdl/serial_port_rate_config.v]
// sample-rate configuration and detection for two audio serial ports
`timescale 1ns/1ns
`include "rate_cfg_regs.vh"
module serial_port_rate_config #(
  parameter CNT_W = 16
) (
  input  wire                mclk,            // 20 MHz device clock
  input  wire                nrst,            // async reset, active low
  input  wire                ce,              // clock enable
  input  wire                hsel,            // slave select
  input  wire [31:0]         haddr,           // byte address
  input  wire [1:0]          htrans,          // transfer type
  input  wire                hwrite,          // write when high
  input  wire [2:0]          hsize,           // transfer size
  input  wire [31:0]         hwdata,          // write data
  input  wire                hready,          // bus ready
  output reg                 hreadyout,       // slave ready
  output reg                 hresp,           // always okay
  output reg  [31:0]         hrdata,          // read data
  input  wire                fsync_first,     // primary port frame sync
  input  wire                fsync_second,    // secondary port frame sync
  output wire [`CODE_W-1:0]  first_rate,      // primary resolved code
  output wire                first_valid,     // primary rate accepted
  output wire [`CODE_W-1:0]  second_rate,     // secondary resolved code
  output wire                second_valid,    // secondary rate accepted
  output reg                 manual_clk_q,    // manual clock setup on
  output reg  [`CODE_W-1:0]  first_setup_q,   // auto setup code, primary
  output reg  [`CODE_W-1:0]  second_setup_q   // auto setup code, secondary
);
  localparam [7:0] CFG_RST = `CFG_RESET;
  localparam       NPORT   = 2;

  reg                      rst_a_q;
  reg                      rst_n_q;
  reg  [7:0]               pri_cfg_q;
  reg  [7:1]               sec_cfg_q;
  reg                      wr_pend_q;
  reg  [`ADDR_W-1:0]       wr_addr_q;
  reg  [31:0]              rd_d;
  reg  [31:0]              status;
  wire [NPORT-1:0]         fsync_pin;
  wire [NPORT-1:0]         fs_rise;
  wire [NPORT-1:0]         tol_v;
  wire [NPORT-1:0]         valid_v;
  wire [NPORT*`CODE_W-1:0] code_v;
  wire [NPORT*`CODE_W-1:0] rate_v;

  // reset released through two flops
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rst_a_q <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      rst_a_q <= 1'b1;
      rst_n_q <= rst_a_q;
    end
  end

  wire [7:0] sec_cfg = {sec_cfg_q, 1'b0};

  // address phase accepted
  wire take    = hsel & hready & (htrans == `HTRANS_NONSEQ);
  wire wr_take = take & hwrite & (hsize == `HSIZE_WORD);
  wire rd_take = take & ~hwrite;
  wire [`ADDR_W-1:0] a_addr = haddr[`ADDR_W-1:0];

  always @* begin
    status                              = 32'h0;
    status[`ST_PRI_CODE_LSB +: `CODE_W] = first_rate;
    status[`ST_PRI_VALID_BIT]           = first_valid;
    status[`ST_SEC_CODE_LSB +: `CODE_W] = second_rate;
    status[`ST_SEC_VALID_BIT]           = second_valid;
    status[`ST_MANUAL_BIT]              = manual_clk_q;
  end

  always @* begin
    case (a_addr)
      `PRI_CFG_ADDR: rd_d = {24'h0, pri_cfg_q};
      `SEC_CFG_ADDR: rd_d = {24'h0, sec_cfg};
      `STATUS_ADDR:  rd_d = status;
      default:       rd_d = 32'h0;
    endcase
  end

  // zero-wait slave, response always okay
  always @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // write address held over for the data phase; non-word writes dropped
  always @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= {`ADDR_W{1'b0}};
    end else if (ce) begin
      wr_pend_q <= wr_take;
      if (wr_take)
        wr_addr_q <= a_addr;
    end
  end

  // read data captured at the address phase, so a read right after a
  // write to the same register still returns the old value
  always @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q)
      hrdata <= 32'h0;
    else if (ce && rd_take)
      hrdata <= rd_d;
  end

  wire pri_hit = wr_pend_q & (wr_addr_q == `PRI_CFG_ADDR);
  wire sec_hit = wr_pend_q & (wr_addr_q == `SEC_CFG_ADDR);

  // configuration registers written in the data phase
  always @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q)
      pri_cfg_q <= CFG_RST;
    else if (ce && pri_hit)
      pri_cfg_q <= hwdata[7:0];
  end

  always @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q)
      sec_cfg_q <= CFG_RST[7:1];
    else if (ce && sec_hit)
      sec_cfg_q <= hwdata[7:1];
  end

  wire [`CODE_W-1:0] pri_code = pri_cfg_q[`CODE_MSB:`CODE_LSB];
  wire [`CODE_W-1:0] sec_code = sec_cfg[`CODE_MSB:`CODE_LSB];
  wire pri_tol  = pri_cfg_q[`TOL_BIT];
  wire sec_tol  = sec_cfg[`TOL_BIT];
  wire manual   = pri_cfg_q[`MODE_BIT];

  assign fsync_pin = {fsync_second, fsync_first};
  assign code_v    = {sec_code, pri_code};
  assign tol_v     = {sec_tol, pri_tol};

  genvar p;
  generate
    for (p = 0; p < NPORT; p = p + 1) begin : g_port
      // frame sync pin is asynchronous: two flops, then one for the edge
      reg [2:0] sync_q;
      always @(posedge mclk or negedge rst_n_q) begin
        if (!rst_n_q)
          sync_q <= 3'h0;
        else if (ce)
          sync_q <= {sync_q[1:0], fsync_pin[p]};
      end
      assign fs_rise[p] = sync_q[1] & ~sync_q[2];

      rate_classifier #(
        .CNT_W    (CNT_W)
      ) u_class (
        .mclk     (mclk),
        .rst_n    (rst_n_q),
        .ce       (ce),
        .fs_rise  (fs_rise[p]),
        .code     (code_v[p*`CODE_W +: `CODE_W]),
        .tol_wide (tol_v[p]),
        .rate_q   (rate_v[p*`CODE_W +: `CODE_W]),
        .valid_q  (valid_v[p])
      );
    end
  endgenerate

  assign first_rate   = rate_v[`CODE_W-1:0];
  assign second_rate  = rate_v[2*`CODE_W-1:`CODE_W];
  assign first_valid  = valid_v[0];
  assign second_valid = valid_v[1];

  always @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q)
      manual_clk_q <= 1'b0;
    else if (ce)
      manual_clk_q <= manual;
  end

  // in manual mode software owns dividers, so automatic setup is parked
  always @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q)
      first_setup_q <= `CODE_AUTO;
    else if (ce) begin
      if (manual)
        first_setup_q <= `CODE_AUTO;
      else if (first_valid)
        first_setup_q <= first_rate;
      else
        first_setup_q <= `CODE_AUTO;
    end
  end

  // the secondary port shares the single manual bit
  always @(posedge mclk or negedge rst_n_q) begin
    if (!rst_n_q)
      second_setup_q <= `CODE_AUTO;
    else if (ce) begin
      if (manual)
        second_setup_q <= `CODE_AUTO;
      else if (second_valid)
        second_setup_q <= second_rate;
      else
        second_setup_q <= `CODE_AUTO;
    end
  end
endmodule // serial_port_rate_config

// [verif/rate_cfg_assertions.sv]
// concurrent checks on the serial port rate config block ports
`timescale 1ns/1ns
`include "rate_cfg_regs.vh"
module rate_cfg_checker #(
  parameter CNT_W = 16
) (
  input wire logic                mclk,           // clock
  input wire logic                nrst,           // async reset
  input wire logic                ce,             // clock enable
  input wire logic                hsel,           // select
  input wire logic [31:0]         haddr,          // address
  input wire logic [1:0]          htrans,         // transfer type
  input wire logic                hwrite,         // write
  input wire logic [2:0]          hsize,          // transfer size
  input wire logic [31:0]         hwdata,         // write data
  input wire logic                hready,         // bus ready
  input wire logic [31:0]         hrdata,         // read data
  input wire logic [`CODE_W-1:0]  first_rate,     // primary code
  input wire logic                first_valid,    // primary valid
  input wire logic [`CODE_W-1:0]  second_rate,    // secondary code
  input wire logic                second_valid,   // secondary valid
  input wire logic                manual_clk_q,   // manual setup
  input wire logic [`CODE_W-1:0]  first_setup_q,  // primary setup
  input wire logic [`CODE_W-1:0]  second_setup_q  // secondary setup
);
  wire take = hsel && hready && htrans == `HTRANS_NONSEQ && ce;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  sequence wr_pri;
    take && hwrite && hsize == `HSIZE_WORD &&
    haddr[9:0] == `PRI_CFG_ADDR ##1 ce ##1 ce;
  endsequence
  sequence rd_at(logic [9:0] a);
    take && !hwrite && haddr[9:0] == a;
  endsequence
  chk_manual_copy: assert property (
    wr_pri |=> manual_clk_q == $past(hwdata[0], 2))
    else $error("manual bit not taken from write");
  chk_manual_setup: assert property (
    manual_clk_q && $past(manual_clk_q) |->
    first_setup_q == 6'h00 && second_setup_q == 6'h00)
    else $error("setup code driven in manual mode");
  chk_auto_setup: assert property (
    $past(ce) && !manual_clk_q && !$past(manual_clk_q) |->
    first_setup_q == ($past(first_valid) ? $past(first_rate) : 6'h00) &&
    second_setup_q == ($past(second_valid) ? $past(second_rate) : 6'h00))
    else $error("auto setup code does not follow rate");
  chk_first_range: assert property (
    first_valid |-> first_rate inside {[`CODE_FIRST:`CODE_LAST]})
    else $error("primary valid with reserved code");
  chk_second_range: assert property (
    second_valid |-> second_rate inside {[`CODE_FIRST:`CODE_LAST]})
    else $error("secondary valid with reserved code");
  chk_sec_bit0: assert property (
    rd_at(`SEC_CFG_ADDR) |=> hrdata[0] == 1'b0)
    else $error("secondary bit 0 not read as zero");
  chk_pri_read: assert property (
    rd_at(`PRI_CFG_ADDR) |=> hrdata[0] == manual_clk_q)
    else $error("primary readback differs from manual bit");
  chk_upper_zero: assert property (
    rd_at(`PRI_CFG_ADDR) |=> hrdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
endmodule // rate_cfg_checker

// [verif/serial_port_rate_config_bench.sv]
// self-checking bench for the serial port rate config block
`timescale 1ns/1ns
`include "rate_cfg_regs.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module serial_port_rate_config_bench;
  logic        mclk = 0, nrst = 0, ce = 1, hsel = 0, hwrite = 0, fs = 0;
  logic [31:0] haddr = 0, hwdata = 0, st = 32'h00018643, e, m;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = `HSIZE_WORD;
  logic        rd_pend = 0, vb;
  logic [7:0]  c;
  logic [5:0]  r;
  logic [31:0] exp_q[$], msk_q[$];
  wire         hreadyout, hresp;
  wire  [31:0] hrdata;
  int          fail_count = 0, compares = 0;
  // cfg, period in cycles, expected code, expected valid
  int tc [9][4] = '{'{0, 417, 20, 1}, '{0, 430, 0, 0}, '{2, 430, 20, 1},
    '{1, 417, 20, 1}, '{8'h50, 500, 0, 0}, '{8'h50, 417, 20, 1},
    '{4, 26, 1, 1}, '{8'ha4, 417, 0, 0}, '{0, 6667, 40, 1}};
  serial_port_rate_config #(.CNT_W(16)) u_dut (
    .mclk(mclk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .fsync_first(fs), .fsync_second(fs),
    .first_rate(), .first_valid(), .second_rate(), .second_valid(),
    .manual_clk_q(), .first_setup_q(), .second_setup_q());
  always #25 mclk = ~mclk;
  function automatic [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic conclude;
    if (fail_count == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wt;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    if (hreadyout !== 1'b1) begin
      fail_count++;
      conclude();
    end
  endtask
  task automatic bus(input logic w, input [9:0] a, input [31:0] d);
    hsel <= 1;
    htrans <= `HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {22'h0, a};
    wt();
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    @(posedge mclk);
  endtask
  task automatic rd(input [9:0] a, input [31:0] ex, mk);
    exp_q.push_back(ex);
    msk_q.push_back(mk);
    bus(0, a, 0);
  endtask
  // last pulse leaves the result of a full period standing for the read
  task automatic frames(input int p);
    repeat (5) begin
      fs <= 1;
      repeat (2) @(posedge mclk);
      fs <= 0;
      repeat (p - 2) @(posedge mclk);
    end
    repeat (60 - p > 0 ? 60 - p : 0) @(posedge mclk);
  endtask
  always @(posedge mclk) begin
    if (rd_pend) begin
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      `CHK(({hresp, hrdata & m}), ({1'b0, e & m}))
    end
    rd_pend <= nrst && hsel && htrans == `HTRANS_NONSEQ && !hwrite && ce;
  end
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1;
    repeat (3) @(posedge mclk);
    rd(`PRI_CFG_ADDR, `CFG_RESET, '1);
    rd(`SEC_CFG_ADDR, `CFG_RESET, '1);
    rd(`STATUS_ADDR, 0, '1);
    repeat (3) begin
      st = lfsr(st);
      bus(1, `PRI_CFG_ADDR, st);
      bus(1, `SEC_CFG_ADDR, st & 32'hfffffffe);
      rd(`PRI_CFG_ADDR, st & 32'hff, '1);
      rd(`SEC_CFG_ADDR, st & 32'hfe, '1);
      rd(`STATUS_ADDR, {15'h0, st[0], 16'h0}, '1);
    end
    bus(1, 10'h0d0, 32'hff);
    rd(10'h0d0, 0, '1);
    ce <= 0;
    bus(1, `PRI_CFG_ADDR, 32'h5a);
    ce <= 1;
    rd(`PRI_CFG_ADDR, st & 32'hff, '1);
    for (int i = 0; i < 9; i++) begin
      c = 8'(tc[i][0]);
      r = 6'(tc[i][2]);
      vb = 1'(tc[i][3]);
      bus(1, `PRI_CFG_ADDR, c);
      bus(1, `SEC_CFG_ADDR, {c[7:1], 1'b0});
      frames(tc[i][1]);
      rd(`STATUS_ADDR, {15'h0, c[0], 1'b0, vb, r, 1'b0, vb, r},
         vb ? '1 : 32'hffffc0c0);
    end
    repeat (3) @(posedge mclk);
    if (exp_q.size() != 0) fail_count++;
    conclude();
  end
endmodule // serial_port_rate_config_bench
bind serial_port_rate_config rate_cfg_checker #(.CNT_W(CNT_W)) u_chk (
  .mclk(mclk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
  .hready(hready),
  .hrdata(hrdata), .first_rate(first_rate), .first_valid(first_valid),
  .second_rate(second_rate), .second_valid(second_valid),
  .manual_clk_q(manual_clk_q), .first_setup_q(first_setup_q),
  .second_setup_q(second_setup_q));
